//--- adcc_conversion_control.v
// Control logic of a two-channel successive-approximation converter.
//
// The address map and the strobed register port were left to the implementer.
`include "adcc_defs.vh"

module adcc_conversion_control #(
  parameter RESULT_W = `ADCC_RESULT_W
) (
  // Clock, reset and enable
  input  wire                    ref_clk,
  input  wire                    rst,
  input  wire                    clk_en,
  // Register port
  input  wire [`ADCC_ADDR_W-1:0] reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  // Analog front end
  output reg                     conv_power,
  output reg                     analog_input_first_sel,
  output reg                     sample_hold,
  output reg                     sar_step,
  input  wire                    sar_bit_async,
  // System
  output wire                    conv_irq,
  output wire                    cpu_halt
);

  // =============================================================
  // State
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  // Software-visible control state
  reg [1:0]              state;
  reg                    converter_enable;
  reg                    channel_select;
  reg                    conversion_start;
  reg                    conversion_done_flag;
  reg                    pseudo_idle_enable;
  reg                    conversion_irq_enable;
  reg [`ADCC_DIV_W-1:0]  clock_divide_field;

  // Converter clock and period counters
  reg [5:0]              div_cnt;
  reg [3:0]              period_cnt;

  // Comparator path, result and read data
  reg [RESULT_W-1:0]     sar_shift;
  reg [RESULT_W-1:0]     conversion_result;
  reg                    sar_meta;
  reg                    sar_sync;
  reg [7:0]              next_rdata;

  function [5:0] div_factor;
    input [`ADCC_DIV_W-1:0] f;
    begin
      if (f == {`ADCC_DIV_W{1'b0}})
        div_factor = `ADCC_DIV_ZERO_AS;
      else
        div_factor = {1'b0, f};
    end
  endfunction

  // Address match; shared by every write decode, while reads decode reg_addr in a case.
  function hit;
    input [`ADCC_ADDR_W-1:0] a;
    input [`ADCC_ADDR_W-1:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  wire wr_div    = reg_wr && hit(reg_addr, `ADCC_ADDR_DIV);
  wire wr_ctrl   = reg_wr && hit(reg_addr, `ADCC_ADDR_CTRL);
  wire wr_ien    = reg_wr && hit(reg_addr, `ADCC_ADDR_IEN);
  wire idle      = (state == ST_IDLE);
  wire busy      = (state == ST_CONV);
  wire div_tick  = (div_cnt == div_factor(clock_divide_field) - 6'h01);
  wire last_per  = (period_cnt == `ADCC_CONV_PERIODS - 4'h1);
  wire conv_end  = busy && div_tick && last_per;
  wire abort     = busy && wr_ctrl && !reg_wdata[`ADCC_EN_BIT];
  wire finish    = conv_end && !abort;
  wire in_hold   = busy && (period_cnt == 4'h0);
  wire step      = busy && div_tick;
  // A start must find the converter enabled and keep it enabled in the
  // same write; a write that clears enable never launches a conversion.
  wire start_req = wr_ctrl && reg_wdata[`ADCC_START_BIT] &&
                   reg_wdata[`ADCC_EN_BIT] && converter_enable && idle;

  // Only the core is halted; this block and others keep running.
  assign cpu_halt = pseudo_idle_enable && busy;
  assign conv_irq = conversion_done_flag && conversion_irq_enable;

  // =============================================================
  // Comparator input synchroniser
  // Two flops guard against a comparator edge close to the clock edge.
  always @(posedge ref_clk) begin
    if (rst) begin
      sar_meta <= 1'b0;
      sar_sync <= 1'b0;
    end else if (clk_en) begin
      sar_meta <= sar_bit_async;
      sar_sync <= sar_meta;
    end
  end

  // =============================================================
  // Software-visible configuration
  always @(posedge ref_clk) begin
    if (rst) begin
      converter_enable      <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_divide_field    <= {`ADCC_DIV_W{1'b0}};
    end else if (clk_en) begin
      if (wr_div)
        clock_divide_field <= reg_wdata[`ADCC_DIV_W-1:0];
      if (wr_ien)
        conversion_irq_enable <= reg_wdata[`ADCC_IEN_BIT];
      if (wr_ctrl)
        converter_enable <= reg_wdata[`ADCC_EN_BIT];
    end
  end

  // =============================================================
  // Channel and pseudo-idle bits
  always @(posedge ref_clk) begin
    if (rst) begin
      channel_select     <= 1'b0;
      pseudo_idle_enable <= 1'b0;
    end else if (clk_en) begin
      // The channel stays put while a conversion samples it.
      if (wr_ctrl && idle)
        channel_select <= reg_wdata[`ADCC_CS_BIT];
      if (start_req)
        pseudo_idle_enable <= reg_wdata[`ADCC_IDLE_BIT];
      else if (finish || abort)
        pseudo_idle_enable <= 1'b0;
    end
  end

  // =============================================================
  // Conversion done flag
  always @(posedge ref_clk) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (clk_en) begin
      // A hardware set wins over a software clear in the same cycle.
      if (finish)
        conversion_done_flag <= 1'b1;
      else if (wr_ctrl && !reg_wdata[`ADCC_DONE_BIT])
        conversion_done_flag <= 1'b0;
    end
  end

  // =============================================================
  // Conversion sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state            <= ST_IDLE;
      conversion_start <= 1'b0;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            conversion_start <= 1'b1;
            state            <= ST_CONV;
          end
        end
        ST_CONV: begin
          // Disabling aborts the conversion and leaves no result.
          if (abort || finish) begin
            conversion_start <= 1'b0;
            state            <= ST_IDLE;
          end
        end
        default: begin
          // A corrupted state code falls back to idle.
          conversion_start <= 1'b0;
          state            <= ST_IDLE;
        end
      endcase
    end
  end

  // =============================================================
  // Converter clock divider and period counter
  // A divide field written during a conversion takes effect at once, so
  // software should change it only while the converter is idle.
  always @(posedge ref_clk) begin
    if (rst) begin
      div_cnt    <= 6'h00;
      period_cnt <= 4'h0;
    end else if (clk_en) begin
      if (!busy) begin
        div_cnt    <= 6'h00;
        period_cnt <= 4'h0;
      end else if (div_tick) begin
        div_cnt    <= 6'h00;
        period_cnt <= period_cnt + 4'h1;
      end else begin
        div_cnt <= div_cnt + 6'h01;
      end
    end
  end

  // =============================================================
  // Successive-approximation shift and result
  always @(posedge ref_clk) begin
    if (rst) begin
      sar_shift         <= {RESULT_W{1'b0}};
      conversion_result <= {RESULT_W{1'b0}};
    end else if (clk_en) begin
      // Period zero is sample and hold; periods one to ten each give one
      // result bit, most significant first.
      if (step && !abort && period_cnt != 4'h0)
        sar_shift <= {sar_shift[RESULT_W-2:0], sar_sync};
      if (finish)
        conversion_result <= {sar_shift[RESULT_W-2:0], sar_sync};
    end
  end

  // =============================================================
  // Analog front end controls
  always @(posedge ref_clk) begin
    if (rst) begin
      conv_power             <= 1'b0;
      analog_input_first_sel <= 1'b0;
    end else if (clk_en) begin
      conv_power             <= converter_enable;
      analog_input_first_sel <= channel_select;
    end
  end

  // =============================================================
  // Sample-and-hold window and step strobes
  always @(posedge ref_clk) begin
    if (rst) begin
      sample_hold <= 1'b0;
      sar_step    <= 1'b0;
    end else if (clk_en) begin
      sample_hold <= in_hold;
      sar_step    <= step;
    end
  end

  // =============================================================
  // Read port
  // Read data stand for one cycle and are zero otherwise, so a stale
  // byte is never taken for a fresh one; reads have no side effects.
  always @* begin
    next_rdata = `ADCC_ZERO8;
    if (reg_rd) begin
      case (reg_addr)
        `ADCC_ADDR_DIV:
          next_rdata = {3'b000, clock_divide_field};
        `ADCC_ADDR_CTRL:
          next_rdata = {1'b0, pseudo_idle_enable, converter_enable,
                        conversion_done_flag, conversion_start,
                        2'b00, channel_select};
        `ADCC_ADDR_HIGH:
          next_rdata = conversion_result[RESULT_W-1:2];
        `ADCC_ADDR_LOW:
          next_rdata = {6'h00, conversion_result[1:0]};
        `ADCC_ADDR_IEN:
          next_rdata = {7'h00, conversion_irq_enable};
        default:
          next_rdata = `ADCC_ZERO8;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `ADCC_ZERO8;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // adcc_conversion_control

//--- adcc_conversion_control_bench.sv
// Self-checking bench for the converter controller.
`include "adcc_defs.vh"
module adcc_conversion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sar = 1'b0;
  logic [7:0] d;
  wire  [7:0] reg_rdata;
  wire        conv_power, first_sel, conv_irq, cpu_halt;
  wire        sample_hold, sar_step;
  int         errors = 0, compares = 0, cyc = 0;
  int         holds = 0, steps = 0;
  always #20 ref_clk = ~ref_clk;
  adcc_conversion_control u_adcc_conversion_control (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_power(conv_power),
    .analog_input_first_sel(first_sel), .sample_hold(sample_hold),
    .sar_step(sar_step),
    .sar_bit_async(sar), .conv_irq(conv_irq), .cpu_halt(cpu_halt));
  // ============================================================
  // Bus and comparison tasks
  task automatic chk(logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_regs;
    rd(`ADCC_ADDR_CTRL);
    chk(d, 8'h00);
    wr(`ADCC_ADDR_DIV, 8'hff);
    rd(`ADCC_ADDR_DIV);
    chk(d, 8'h1f);
    wr(`ADCC_ADDR_CTRL, 8'h08);
    rd(`ADCC_ADDR_CTRL);
    chk(d, 8'h00);
  endtask
  task automatic t_conv(logic [7:0] f, logic i, logic c, logic e, logic s);
    logic [7:0] go;
    int n, fd, h0, s0;
    go = {1'h0, i, 6'h28} | {7'h00, c};
    fd = (f == 8'h00) ? 32 : f;
    n = 11 * fd;
    sar <= s;
    wr(`ADCC_ADDR_DIV, f);
    wr(`ADCC_ADDR_IEN, {7'h00, e});
    wr(`ADCC_ADDR_CTRL, {7'h10, c});
    repeat (4) @(posedge ref_clk);
    h0 = holds;
    s0 = steps;
    wr(`ADCC_ADDR_CTRL, go);
    #1 chk({7'h00, cpu_halt}, {7'h00, i});
    repeat (n - 3) @(posedge ref_clk);
    rd(`ADCC_ADDR_CTRL);
    chk(d, go);
    rd(`ADCC_ADDR_CTRL);
    chk(d, {7'h18, c});
    chk({7'h00, conv_irq}, {7'h00, e});
    chk(8'(holds - h0), 8'(fd));
    chk(8'(steps - s0), 8'h0b);
    rd(`ADCC_ADDR_HIGH);
    chk(d, {8{s}});
    rd(`ADCC_ADDR_LOW);
    chk(d, {6'h00, s, s});
    chk({7'h00, first_sel}, {7'h00, c});
    wr(`ADCC_ADDR_CTRL, {7'h10, c});
    #1 chk({7'h00, conv_irq}, 8'h00);
  endtask
  task automatic t_abort;
    wr(`ADCC_ADDR_CTRL, 8'h20);
    repeat (4) @(posedge ref_clk);
    wr(`ADCC_ADDR_CTRL, 8'h68);
    wr(`ADCC_ADDR_CTRL, 8'h00);
    #1 chk({7'h00, cpu_halt}, 8'h00);
    rd(`ADCC_ADDR_CTRL);
    chk(d, 8'h00);
  endtask
  task automatic final_report;
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_conv(8'h01, 1'b1, 1'b1, 1'b1, 1'b1);
    t_conv(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    t_conv(8'h03, 1'b1, 1'b0, 1'b1, 1'b1);
    t_abort;
    final_report;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (sample_hold) holds++;
    if (sar_step) steps++;
    if (cyc == 5000) begin
      errors++;
      final_report;
    end
  end
endmodule // adcc_conversion_control_bench

//--- adcc_conversion_control_chk.sv
// Port assertions for the converter controller.
`include "adcc_defs.vh"
module adcc_chk (
  input wire       ref_clk,
  input wire       rst,
  input wire       clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       conv_power,
  input wire       conv_irq,
  input wire       cpu_halt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Shadow of the divide field so the conversion length can be judged.
  logic [4:0] div;
  logic [8:0] cnt;
  wire wc = clk_en && reg_wr && reg_addr == `ADCC_ADDR_CTRL;
  wire wi = clk_en && reg_wr && reg_addr == `ADCC_ADDR_IEN;
  wire [8:0] len = (div == 5'h00) ? 9'h160 : div * 9'h00b;
  always @(posedge ref_clk) begin
    if (rst) begin
      div <= 5'h00;
      cnt <= 9'h000;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `ADCC_ADDR_DIV) div <= reg_wdata[4:0];
      cnt <= cpu_halt ? cnt + 9'h001 : 9'h000;
    end
  end
  sequence s_go;
    wc && reg_wdata[6] && reg_wdata[5] && reg_wdata[3] && conv_power
      && !cpu_halt;
  endsequence
  // A fall right after a write may be an abort, so it is left out.
  sequence s_end;
    $fell(cpu_halt) && !$past(reg_wr);
  endsequence
  AST_HALT_HOLD: assert property (s_go |=> cpu_halt [*8])
    else $error("cpu not held after start");
  AST_CONV_LEN: assert property (s_end |-> cnt == len)
    else $error("conversion length wrong");
  AST_DIV_RSV: assert property ($past(reg_rd && reg_addr == `ADCC_ADDR_DIV)
    |-> reg_rdata[7:5] == 3'h0)
    else $error("divider upper bits not zero");
  AST_START_READ: assert property ($past(reg_rd && clk_en && cpu_halt
    && reg_addr == `ADCC_ADDR_CTRL) |-> reg_rdata[3] && reg_rdata[6])
    else $error("start bit not set while converting");
  AST_IRQ_HOLD: assert property (conv_irq && !wc && !wi |=> conv_irq)
    else $error("done request dropped");
  AST_IRQ_OFF: assert property (wi && !reg_wdata[0] |=> !conv_irq)
    else $error("request while disabled");
  AST_PWR_ON: assert property (wc && reg_wdata[5] |-> ##[1:2] conv_power)
    else $error("converter not powered");
  AST_PWR_OFF: assert property (wc && !reg_wdata[5] |-> ##[1:2] !conv_power)
    else $error("converter not in standby");
  AST_ABORT: assert property (wc && !reg_wdata[5] |=> !cpu_halt)
    else $error("halt kept after disable");
endmodule // adcc_chk
bind adcc_conversion_control adcc_chk u_chk (.*);

//--- adcc_defs.vh
// Register map, field positions and constants of the converter controller.
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// =============================================================
// Register addresses
`define ADCC_ADDR_W        8
`define ADCC_ADDR_DIV      8'hf2
`define ADCC_ADDR_CTRL     8'hf3
`define ADCC_ADDR_LOW      8'hf4
`define ADCC_ADDR_HIGH     8'hf5
`define ADCC_ADDR_IEN      8'hf6

// =============================================================
// Control register fields
`define ADCC_CS_BIT        0
`define ADCC_START_BIT     3
`define ADCC_DONE_BIT      4
`define ADCC_EN_BIT        5
`define ADCC_IDLE_BIT      6
`define ADCC_CTRL_WMASK    8'h79

// =============================================================
// Divider, interrupt enable and conversion constants
`define ADCC_DIV_W         5
`define ADCC_DIV_ZERO_AS   6'h20
`define ADCC_IEN_BIT       0
`define ADCC_CONV_PERIODS  4'hb
`define ADCC_RESULT_W      10
`define ADCC_ZERO8         8'h00

`endif
